// ===== hdl/sccfg_top.v
// System clock configuration and identification register block
`timescale 1ns/1ps
`include "sccfg_regs.vh"
module sccfg_top (
  input wire clk_i,
  input wire nrst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [`SCCFG_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire pin_program_select_pin_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  output reg [7:0] syspll_feedback_divider_o,
  output reg crystal_amp_enable_o,
  output reg [1:0] input_predivider_o,
  output reg [3:0] predivide_ratio_o,
  output reg input_doubler_enable_o,
  output reg [20:0] nominal_period_fs_o,
  output reg [19:0] stability_period_ms_o,
  output reg stability_timer_restart_o,
  output reg [15:0] user_scratch_o,
  output reg pin_origin_o
);
  // Register write strobes
  wire wr_commit = reg_wr_i && (reg_addr_i == `SCCFG_OFS_COMMIT);
  wire wr_sc_lo = reg_wr_i && (reg_addr_i == `SCCFG_OFS_SCRATCH_LO);
  wire wr_sc_hi = reg_wr_i && (reg_addr_i == `SCCFG_OFS_SCRATCH_HI);
  wire wr_fbdiv = reg_wr_i && (reg_addr_i == `SCCFG_OFS_FBDIV);
  wire wr_incfg = reg_wr_i && (reg_addr_i == `SCCFG_OFS_INCFG);
  wire wr_nomp0 = reg_wr_i && (reg_addr_i == `SCCFG_OFS_NOMP0);
  wire wr_nomp1 = reg_wr_i && (reg_addr_i == `SCCFG_OFS_NOMP1);
  wire wr_nomp2 = reg_wr_i && (reg_addr_i == `SCCFG_OFS_NOMP2);
  wire wr_stab0 = reg_wr_i && (reg_addr_i == `SCCFG_OFS_STAB0);
  wire wr_stab1 = reg_wr_i && (reg_addr_i == `SCCFG_OFS_STAB1);
  wire wr_stab2 = reg_wr_i && (reg_addr_i == `SCCFG_OFS_STAB2);
  wire commit = wr_commit && reg_wdata_i[`SCCFG_BIT_COMMIT];

  // Scratch code is live: no commit needed, drives user_scratch_o and the readback mux
  reg [7:0] scratch_lo_r;
  reg [7:0] scratch_hi_r;
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      scratch_lo_r <= `SCCFG_RST_SCRATCH;
      scratch_hi_r <= `SCCFG_RST_SCRATCH;
    end else begin
      if (wr_sc_lo) begin
        scratch_lo_r <= reg_wdata_i;
      end
      if (wr_sc_hi) begin
        scratch_hi_r <= reg_wdata_i;
      end
    end
  end

  // Feedback divider; out-of-range host writes are clamped to minimum
  wire [7:0] fbdiv_buf;
  wire [7:0] fbdiv_act;
  wire [7:0] fbdiv_wdata = (reg_wdata_i < `SCCFG_FBDIV_MIN) ?
    `SCCFG_FBDIV_MIN : reg_wdata_i;
  sccfg_wreg #(.W(8), .RST(`SCCFG_RST_FBDIV)) u_fbdiv (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_fbdiv),
    .wdata_i(fbdiv_wdata),
    .commit_i(commit),
    .buf_o(fbdiv_buf),
    .act_o(fbdiv_act)
  );

  // Input configuration: xtal, predivider, doubler in bits 3..0
  wire [3:0] incfg_buf;
  wire [3:0] incfg_act;
  sccfg_wreg #(.W(4), .RST({`SCCFG_RST_XTAL, `SCCFG_RST_PDIV,
    `SCCFG_RST_DOUBLER})) u_incfg (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_incfg),
    .wdata_i(reg_wdata_i[3:0]),
    .commit_i(commit),
    .buf_o(incfg_buf),
    .act_o(incfg_act)
  );

  // Nominal period, 21 bits in femtoseconds
  wire [20:0] nomp_buf;
  wire [20:0] nomp_act;
  sccfg_wreg #(.W(8), .RST(`SCCFG_RST_NOMP0)) u_nomp0 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_nomp0),
    .wdata_i(reg_wdata_i),
    .commit_i(commit),
    .buf_o(nomp_buf[7:0]),
    .act_o(nomp_act[7:0])
  );
  sccfg_wreg #(.W(8), .RST(`SCCFG_RST_NOMP1)) u_nomp1 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_nomp1),
    .wdata_i(reg_wdata_i),
    .commit_i(commit),
    .buf_o(nomp_buf[15:8]),
    .act_o(nomp_act[15:8])
  );
  sccfg_wreg #(.W(5), .RST(`SCCFG_RST_NOMP2)) u_nomp2 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_nomp2),
    .wdata_i(reg_wdata_i[4:0]),
    .commit_i(commit),
    .buf_o(nomp_buf[20:16]),
    .act_o(nomp_act[20:16])
  );

  // Stability period, 20 bits in milliseconds
  wire [19:0] stab_buf;
  wire [19:0] stab_act;
  sccfg_wreg #(.W(8), .RST(`SCCFG_RST_STAB0)) u_stab0 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_stab0),
    .wdata_i(reg_wdata_i),
    .commit_i(commit),
    .buf_o(stab_buf[7:0]),
    .act_o(stab_act[7:0])
  );
  sccfg_wreg #(.W(8), .RST(`SCCFG_RST_STAB1)) u_stab1 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_stab1),
    .wdata_i(reg_wdata_i),
    .commit_i(commit),
    .buf_o(stab_buf[15:8]),
    .act_o(stab_act[15:8])
  );
  sccfg_wreg #(.W(4), .RST(`SCCFG_RST_STAB2)) u_stab2 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_stab2),
    .wdata_i(reg_wdata_i[3:0]),
    .commit_i(commit),
    .buf_o(stab_buf[19:16]),
    .act_o(stab_act[19:16])
  );

  // Restart request is held until commit, then pulses and clears itself
  reg restart_pend_r;
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      restart_pend_r <= 1'b0;
    end else if (wr_stab2 && reg_wdata_i[`SCCFG_BIT_STAB_RESTART]) begin
      restart_pend_r <= 1'b1;
    end else if (commit) begin
      restart_pend_r <= 1'b0;
    end
  end

  // Strap origin flag
  wire origin;
  sccfg_strap u_strap (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(pin_program_select_pin_i),
    .flag_o(origin)
  );

  // Identity word split into bytes by part-select, never by truncation
  wire [15:0] family_code = `SCCFG_FAMILY_CODE;

  // Readback mux; reserved bits and unmapped addresses read zero
  reg [7:0] rdata;
  always @* begin
    rdata = 8'h00;
    case (reg_addr_i)
      `SCCFG_OFS_SCRATCH_LO: rdata = scratch_lo_r;
      `SCCFG_OFS_SCRATCH_HI: rdata = scratch_hi_r;
      `SCCFG_OFS_REVISION: rdata = `SCCFG_REVISION_CODE;
      `SCCFG_OFS_FAMILY_LO: rdata = family_code[7:0];
      `SCCFG_OFS_FAMILY_HI: rdata = family_code[15:8];
      `SCCFG_OFS_FBDIV: rdata = fbdiv_buf;
      `SCCFG_OFS_INCFG: rdata = {3'b000, origin, incfg_buf};
      `SCCFG_OFS_NOMP0: rdata = nomp_buf[7:0];
      `SCCFG_OFS_NOMP1: rdata = nomp_buf[15:8];
      `SCCFG_OFS_NOMP2: rdata = {3'b000, nomp_buf[20:16]};
      `SCCFG_OFS_STAB0: rdata = stab_buf[7:0];
      `SCCFG_OFS_STAB1: rdata = stab_buf[15:8];
      `SCCFG_OFS_STAB2: rdata = {3'b000, 1'b0, stab_buf[19:16]};
      default: rdata = 8'h00;
    endcase
  end

  // Predivider code to ratio, one-hot 1/2/4/8
  reg [3:0] ratio;
  always @* begin
    case (incfg_act[`SCCFG_BIT_PDIV_HI:`SCCFG_BIT_PDIV_LO])
      2'b00: ratio = 4'h1;
      2'b01: ratio = 4'h2;
      2'b10: ratio = 4'h4;
      default: ratio = 4'h8;
    endcase
  end

  // Registered outputs
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
      syspll_feedback_divider_o <= `SCCFG_RST_FBDIV;
      crystal_amp_enable_o <= `SCCFG_RST_XTAL;
      input_predivider_o <= `SCCFG_RST_PDIV;
      predivide_ratio_o <= 4'h1;
      input_doubler_enable_o <= `SCCFG_RST_DOUBLER;
      nominal_period_fs_o <= {`SCCFG_RST_NOMP2, `SCCFG_RST_NOMP1,
        `SCCFG_RST_NOMP0};
      stability_period_ms_o <= {`SCCFG_RST_STAB2, `SCCFG_RST_STAB1,
        `SCCFG_RST_STAB0};
      stability_timer_restart_o <= 1'b0;
      user_scratch_o <= 16'h0000;
      pin_origin_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata : reg_rdata_o;
      reg_rvalid_o <= reg_rd_i;
      syspll_feedback_divider_o <= fbdiv_act;
      crystal_amp_enable_o <= incfg_act[`SCCFG_BIT_XTAL];
      input_predivider_o <= incfg_act[`SCCFG_BIT_PDIV_HI:`SCCFG_BIT_PDIV_LO];
      predivide_ratio_o <= ratio;
      input_doubler_enable_o <= incfg_act[`SCCFG_BIT_DOUBLER];
      nominal_period_fs_o <= nomp_act;
      stability_period_ms_o <= stab_act;
      stability_timer_restart_o <= restart_pend_r && commit;
      user_scratch_o <= {scratch_hi_r, scratch_lo_r};
      pin_origin_o <= origin;
    end
  end
endmodule // sccfg_top

// ===== hdl/sccfg_regs.vh
// Register offsets, field positions, reset values and identity codes for sccfg
`ifndef SCCFG_REGS_VH
`define SCCFG_REGS_VH
`define SCCFG_ADDR_W 16
`define SCCFG_OFS_COMMIT 16'h0005
`define SCCFG_OFS_SCRATCH_LO 16'h0006
`define SCCFG_OFS_SCRATCH_HI 16'h0007
`define SCCFG_OFS_REVISION 16'h000A
`define SCCFG_OFS_FAMILY_LO 16'h000C
`define SCCFG_OFS_FAMILY_HI 16'h000D
`define SCCFG_OFS_FBDIV 16'h0100
`define SCCFG_OFS_INCFG 16'h0101
`define SCCFG_OFS_NOMP0 16'h0103
`define SCCFG_OFS_NOMP1 16'h0104
`define SCCFG_OFS_NOMP2 16'h0105
`define SCCFG_OFS_STAB0 16'h0106
`define SCCFG_OFS_STAB1 16'h0107
`define SCCFG_OFS_STAB2 16'h0108
`define SCCFG_BIT_COMMIT 0
`define SCCFG_BIT_ORIGIN 4
`define SCCFG_BIT_XTAL 3
`define SCCFG_BIT_PDIV_HI 2
`define SCCFG_BIT_PDIV_LO 1
`define SCCFG_BIT_DOUBLER 0
`define SCCFG_BIT_STAB_RESTART 4
`define SCCFG_RST_SCRATCH 8'h00
`define SCCFG_RST_FBDIV 8'h08
`define SCCFG_FBDIV_MIN 8'h04
`define SCCFG_RST_XTAL 1'b1
`define SCCFG_RST_PDIV 2'h0
`define SCCFG_RST_DOUBLER 1'b1
`define SCCFG_RST_NOMP0 8'h0E
`define SCCFG_RST_NOMP1 8'h67
`define SCCFG_RST_NOMP2 5'h13
`define SCCFG_RST_STAB0 8'h32
`define SCCFG_RST_STAB1 8'h00
`define SCCFG_RST_STAB2 4'h0
// Arbitrary neutral identity values
`define SCCFG_REVISION_CODE 8'h5A
`define SCCFG_FAMILY_CODE 16'hA5_C3
`endif

// ===== hdl/sccfg_wreg.v
// Buffered register field of W bits with reset value and commit copy
`timescale 1ns/1ps
module sccfg_wreg #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire clk_i,
  input wire nrst_i,
  input wire wr_i,
  input wire [W-1:0] wdata_i,
  input wire commit_i,
  output reg [W-1:0] buf_o,
  output reg [W-1:0] act_o
);
  // Buffer takes host data, active copy only moves on commit
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      buf_o <= RST;
      act_o <= RST;
    end else begin
      if (wr_i) begin
        buf_o <= wdata_i;
      end
      if (commit_i) begin
        act_o <= buf_o;
      end
    end
  end
endmodule // sccfg_wreg

// ===== hdl/sccfg_strap.v
// Capture of the pin-program select level after reset release
`timescale 1ns/1ps
module sccfg_strap (
  input wire clk_i,
  input wire nrst_i,
  input wire pin_i,
  output reg flag_o
);
  reg armed_r;
  // Sample on first clock after release; reset only loads constants
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      armed_r <= 1'b1;
      flag_o <= 1'b0;
    end else if (armed_r) begin
      armed_r <= 1'b0;
      flag_o <= pin_i;
    end
  end
endmodule // sccfg_strap

// ===== verification/sccfg_checker.sv
// Port assertions for the sccfg register block
`timescale 1ns/1ps
module sccfg_checker (
  input wire clk_i,
  input wire nrst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rvalid_o,
  input wire [7:0] syspll_feedback_divider_o,
  input wire [1:0] input_predivider_o,
  input wire [3:0] predivide_ratio_o,
  input wire [20:0] nominal_period_fs_o,
  input wire stability_timer_restart_o,
  input wire [15:0] user_scratch_o,
  input wire pin_origin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Decoded host strobes
  wire commit_w = reg_wr_i && reg_addr_i == 16'h0005 && reg_wdata_i[0];
  wire scr_w = reg_wr_i && reg_addr_i[15:1] == 15'h0003;
  // Outputs move on the edge after the commit edge
  sequence after_commit;
    $past(commit_w, 2);
  endsequence
  // Restart pulse is launched on the commit edge itself
  sequence commit_prev;
    $past(commit_w);
  endsequence
  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without read");
  a_div_floor: assert property (syspll_feedback_divider_o >= 8'h04)
    else $error("divider below four");
  a_ratio_map: assert property (
    predivide_ratio_o == (4'h1 << input_predivider_o))
    else $error("ratio not matching code");
  a_div_hold: assert property (
    $changed(syspll_feedback_divider_o) |-> after_commit)
    else $error("divider moved without commit");
  a_nom_hold: assert property (
    $changed(nominal_period_fs_o) |-> after_commit)
    else $error("period moved without commit");
  a_restart_cause: assert property (
    $rose(stability_timer_restart_o) |-> commit_prev)
    else $error("restart without commit");
  a_restart_pulse: assert property (
    stability_timer_restart_o |=> !stability_timer_restart_o)
    else $error("restart longer than one cycle");
  a_scratch_live: assert property (
    $changed(user_scratch_o) |-> $past(scr_w, 2))
    else $error("scratch moved without write");
  a_origin_hold: assert property (
    $changed(pin_origin_o) |-> !$past(nrst_i, 3))
    else $error("origin flag moved after reset");
endmodule // sccfg_checker
bind sccfg_top sccfg_checker sccfg_checker_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rvalid_o(reg_rvalid_o),
  .syspll_feedback_divider_o(syspll_feedback_divider_o),
  .input_predivider_o(input_predivider_o),
  .predivide_ratio_o(predivide_ratio_o),
  .nominal_period_fs_o(nominal_period_fs_o),
  .stability_timer_restart_o(stability_timer_restart_o),
  .user_scratch_o(user_scratch_o), .pin_origin_o(pin_origin_o));

// ===== verification/sccfg_host.sv
// Host processor model on the sccfg register bus
`timescale 1ns/1ps
module sccfg_host (
  input wire clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire [7:0] reg_rdata_i,
  input wire reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 16'h0000;
    reg_wdata_o = 8'h00;
  end
  // Released bus shows inverted values so stale data is never reused
  task automatic drop();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
  // One byte write; commit and restart are plain writes too
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    drop();
  endtask
  // One byte read, answer taken while it stands after the request edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    d = reg_rdata_i;
    v = reg_rvalid_i;
    drop();
  endtask
endmodule // sccfg_host

// ===== verification/tb_sccfg_top.sv
// Self-checking bench for the sccfg register block
`timescale 1ns/1ps
`include "sccfg_regs.vh"
module tb_sccfg_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pin_i = 1'b1;
  logic wr, rd, rv, rst_o, org, xtal, dbl, v;
  logic [15:0] addr, scr;
  logic [7:0] wd, rdat, div, d;
  logic [1:0] pdc;
  logic [3:0] ratio;
  logic [20:0] nom;
  logic [19:0] stab;
  logic [32:0] r;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int pulses = 0;
  // Rows: write flag, address, write data, expected readback
  logic [32:0] rows [28] = '{
    33'h0_0006_0000, 33'h0_0007_0000, 33'h0_0100_0008, 33'h0_0101_0019,
    33'h0_0103_000E, 33'h0_0104_0067, 33'h0_0105_0013, 33'h0_0106_0032,
    33'h0_0107_0000, 33'h0_0108_0000, 33'h0_0005_0000, 33'h0_0002_0000,
    {17'h0_000A, 8'h00, `SCCFG_REVISION_CODE},
    {17'h0_000C, 8'h00, 8'(`SCCFG_FAMILY_CODE)},
    {17'h0_000D, 8'h00, 8'(`SCCFG_FAMILY_CODE >> 8)},
    {17'h1_000A, 8'hFF, `SCCFG_REVISION_CODE},
    {17'h1_000D, 8'hFF, 8'(`SCCFG_FAMILY_CODE >> 8)},
    33'h1_0006_A5A5, 33'h1_0007_3C3C, 33'h1_0100_2020, 33'h1_0101_FF1F,
    33'h1_0103_3434, 33'h1_0104_1212, 33'h1_0105_FF1F, 33'h1_0106_5656,
    33'h1_0107_7878, 33'h1_0108_FF0F, 33'h1_0002_FF00};
  sccfg_top sccfg_top_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
    .pin_program_select_pin_i(pin_i), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .syspll_feedback_divider_o(div),
    .crystal_amp_enable_o(xtal), .input_predivider_o(pdc),
    .predivide_ratio_o(ratio), .input_doubler_enable_o(dbl),
    .nominal_period_fs_o(nom), .stability_period_ms_o(stab),
    .stability_timer_restart_o(rst_o), .user_scratch_o(scr),
    .pin_origin_o(org));
  sccfg_host sccfg_host_inst (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wd), .reg_rdata_i(rdat),
    .reg_rvalid_i(rv));
  always #5 clk_i = ~clk_i;
  // Cycle ceiling and restart pulse count
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rst_o === 1'b1) pulses <= pulses + 1;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(string n, logic [20:0] e, logic [20:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(logic [15:0] a, logic [7:0] e);
    sccfg_host_inst.rd(a, d, v);
    chk("rvalid", 21'h1, {20'h0, v});
    chk("rdata", {13'h0, e}, {13'h0, d});
  endtask
  // Commit, then let the active outputs settle two edges later
  task automatic commit();
    sccfg_host_inst.wr(16'h0005, 8'h01);
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      if (r[32]) sccfg_host_inst.wr(r[31:16], r[15:8]);
      rdchk(r[31:16], r[7:0]);
    end
    chk("origin", 21'h1, {20'h0, org});
    chk("scratch", 21'h3CA5, {5'h0, scr});
    chk("div", 21'h8, {13'h0, div});
    chk("nom", 21'h13670E, nom);
    chk("stab", 21'h32, {1'b0, stab});
    chk("pulses", 21'h0, 21'(pulses));
    commit();
    chk("div", 21'h20, {13'h0, div});
    chk("nom", 21'h1F1234, nom);
    chk("stab", 21'hF_7856, {1'b0, stab});
    chk("cfg", 21'h11E, {16'h0, xtal, pdc, dbl, 1'b0} | 21'(ratio) << 5);
    commit();
    chk("pulses", 21'h1, 21'(pulses));
    // Every predivider code with amplifier and doubler off
    for (int c = 0; c < 4; c++) begin
      sccfg_host_inst.wr(16'h0101, 8'(c << 1));
      commit();
      chk("ratio", 21'(1 << c), {17'h0, ratio});
      chk("code", 21'(c), {17'h0, xtal, dbl, pdc});
    end
    // Divider below the floor is clamped
    sccfg_host_inst.wr(16'h0100, 8'h03);
    commit();
    chk("div", 21'h4, {13'h0, div});
    // Second reset with the strap pin low
    pin_i = 1'b0;
    nrst_i = 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    rdchk(16'h0101, 8'h09);
    chk("origin", 21'h0, {20'h0, org});
    chk("div", 21'h8, {13'h0, div});
    // Strap level after reset must not follow the pin
    pin_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk("origin", 21'h0, {20'h0, org});
    conclude();
  end
endmodule // tb_sccfg_top
